// ===== pkg/adc_port_pkg.sv
// Purpose: types of the converter output and configuration port
// Assumes: constants live in adc_port_regs.svh
// Notes:   none
package adc_port_pkg;

  typedef enum logic [1:0] {
    MODE_FULL_CMOS,
    MODE_DDR_CMOS,
    MODE_DDR_LVDS
  } out_mode_e;

  typedef struct packed {
    logic [13:0] code;
    logic        over;
  } sample_s;

  typedef struct packed {
    out_mode_e   mode;
    logic        twos;
    logic        dcs;
    logic        sleep;
    logic [1:0]  phase;
    logic        drive_half;
    logic        term;
  } cfg_s;

endpackage

// ===== pkg/adc_port_regs.svh
// Purpose: constants of the converter output and configuration port
// Assumes: 200 MHz system clock, 16-bit serial frames, 8-bit registers
// Notes:   offsets are serial register addresses
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH

`define ADC_FRAME_BITS     5'h10
`define ADC_ADDR_LAST_BIT  5'h07
`define ADC_DATA_LAST_BIT  5'h0F

`define ADC_REG_POWER      7'h00
`define ADC_REG_TIMING     7'h01
`define ADC_REG_OUTPUT     7'h02
`define ADC_REG_FORMAT     7'h03

`define ADC_POWER_SLEEP    0
`define ADC_TIMING_DCS     0
`define ADC_TIMING_PHASE   1
`define ADC_OUTPUT_MODE    0
`define ADC_OUTPUT_HALF    2
`define ADC_OUTPUT_TERM    3
`define ADC_FORMAT_TWOS    0

`define ADC_RST_POWER      8'h00
`define ADC_RST_TIMING     8'h00
`define ADC_RST_OUTPUT     8'h00
`define ADC_RST_FORMAT     8'h00

`define ADC_MODE_CODE_DDR  2'h1
`define ADC_MODE_CODE_LVDS 2'h2

`define ADC_CLK_MHZ        200
`define ADC_STOP_NS        1000
`define ADC_STOP_CYC       ((`ADC_STOP_NS * `ADC_CLK_MHZ) / 1000)
`define ADC_LOCK_CYCLES    7'h64
`define ADC_PERIOD_TOL     10'h001

`endif

// ===== rtl/adc_output_and_config_port.sv
// Purpose: sample output formatting and configuration port of the converter
// Assumes: conversion results arrive on i_clk; serial clock is its own domain
// Notes:   config crosses to i_clk bit by bit; it is quasi-static
`timescale 1ns/10ps
`include "adc_port_regs.svh"

module adc_output_and_config_port #(
  parameter int LATENCY = 5,
  parameter int CW      = 10
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_serial_clk,
  input  wire logic                 i_program_path_strap,
  input  wire logic                 i_chip_select_n,
  input  wire logic                 i_serial_data_in,
  input  wire logic                 i_sample_clock_pos,
  input  wire logic                 i_sample_clock_neg,
  input  wire adc_port_pkg::sample_s i_conv_sample,
  output logic [13:0]               o_sample_word_lines,
  output logic [6:0]                o_ddr_bit_pair_line,
  output logic                      o_forwarded_clock_pos,
  output logic                      o_forwarded_clock_neg,
  output logic                      o_range_exceeded_flag,
  output logic                      o_lvds_enable,
  output logic                      o_lvds_drive_half,
  output logic                      o_lvds_term_en,
  output logic                      o_dcs_enable,
  output logic                      o_dcs_locked,
  output logic                      o_sleep,
  output logic                      o_serial_data_out,
  output logic                      o_serial_data_oe
);
  import adc_port_pkg::*;

  // --------------------------------------------------------------
  // serial port, serial clock domain
  // --------------------------------------------------------------
  logic        frame_rst;
  logic        strap_k1_q;
  logic        strap_k2_q;
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [6:0]  addr_q;
  logic        rd_q;
  logic [7:0]  rd_sh_q;
  logic        sdo_low_q;
  logic [7:0]  reg_power_q;
  logic [7:0]  reg_timing_q;
  logic [7:0]  reg_output_q;
  logic [7:0]  reg_format_q;
  logic        serial_mode_k;
  logic        at_addr;
  logic        at_data;
  logic [6:0]  addr_in;
  logic [7:0]  data_in;
  logic [7:0]  rd_data;
  logic        wr_en;
  logic        in_read;

  // frame state clears whenever chip select is high
  assign frame_rst     = i_rst | i_chip_select_n;
  assign serial_mode_k = ~strap_k2_q;
  assign at_addr       = bit_cnt_q == `ADC_ADDR_LAST_BIT;
  assign at_data       = bit_cnt_q == `ADC_DATA_LAST_BIT;
  assign addr_in       = {shift_q[5:0], i_serial_data_in};
  assign data_in       = {shift_q[6:0], i_serial_data_in};
  assign wr_en         = at_data & ~rd_q & serial_mode_k;
  assign in_read       = rd_q & (bit_cnt_q > `ADC_ADDR_LAST_BIT) &
                         (bit_cnt_q < `ADC_FRAME_BITS);
  assign rd_data = (addr_in == `ADC_REG_POWER)  ? reg_power_q  :
                   (addr_in == `ADC_REG_TIMING) ? reg_timing_q :
                   (addr_in == `ADC_REG_OUTPUT) ? reg_output_q :
                   (addr_in == `ADC_REG_FORMAT) ? reg_format_q : 8'h00;

  always_ff @(posedge i_serial_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_k1_q <= 1'b0;
      strap_k2_q <= 1'b0;
    end else begin
      strap_k1_q <= i_program_path_strap;
      strap_k2_q <= strap_k1_q;
    end
  end

  // data shifts in on the rising serial clock edge
  always_ff @(posedge i_serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 15'h0000;
    end else begin
      shift_q <= {shift_q[13:0], i_serial_data_in};
      if (bit_cnt_q != `ADC_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge i_serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      addr_q  <= 7'h00;
      rd_q    <= 1'b0;
      rd_sh_q <= 8'hFF;
    end else if (at_addr) begin
      addr_q  <= addr_in;
      rd_q    <= shift_q[6] & serial_mode_k;
      rd_sh_q <= rd_data;
    end else begin
      rd_sh_q <= {rd_sh_q[6:0], 1'b1};
    end
  end

  always_ff @(posedge i_serial_clk or posedge i_rst) begin
    if (i_rst) begin
      reg_power_q  <= `ADC_RST_POWER;
      reg_timing_q <= `ADC_RST_TIMING;
      reg_output_q <= `ADC_RST_OUTPUT;
      reg_format_q <= `ADC_RST_FORMAT;
    end else if (wr_en) begin
      case (addr_q)
        `ADC_REG_POWER:  reg_power_q  <= data_in;
        `ADC_REG_TIMING: reg_timing_q <= data_in;
        `ADC_REG_OUTPUT: reg_output_q <= data_in;
        `ADC_REG_FORMAT: reg_format_q <= data_in;
        default: begin
        end
      endcase
    end
  end

  // readback bit changes on the falling edge, pulls low or releases
  always_ff @(negedge i_serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      sdo_low_q <= 1'b0;
    end else begin
      sdo_low_q <= in_read & ~rd_sh_q[7];
    end
  end

  // pin only ever pulled low; released outside readback
  assign o_serial_data_out = 1'b0;
  assign o_serial_data_oe  = sdo_low_q;

  // --------------------------------------------------------------
  // crossings into i_clk
  // --------------------------------------------------------------
  logic [8:0] cfg_raw;
  logic [8:0] cfg_m1_q;
  logic [8:0] cfg_m2_q;
  logic [3:0] pin_m1_q;
  logic [3:0] pin_m2_q;
  logic [1:0] enc_m1_q;
  logic [1:0] enc_m2_q;

  assign cfg_raw = {reg_power_q[`ADC_POWER_SLEEP],
                    reg_timing_q[`ADC_TIMING_DCS],
                    reg_timing_q[`ADC_TIMING_PHASE +: 2],
                    reg_output_q[`ADC_OUTPUT_MODE +: 2],
                    reg_output_q[`ADC_OUTPUT_HALF],
                    reg_output_q[`ADC_OUTPUT_TERM],
                    reg_format_q[`ADC_FORMAT_TWOS]};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_m1_q <= 9'h000;
      cfg_m2_q <= 9'h000;
      pin_m1_q <= 4'h0;
      pin_m2_q <= 4'h0;
      enc_m1_q <= 2'h0;
      enc_m2_q <= 2'h0;
    end else begin
      cfg_m1_q <= cfg_raw;
      cfg_m2_q <= cfg_m1_q;
      pin_m1_q <= {i_program_path_strap, i_chip_select_n,
                   i_serial_clk, i_serial_data_in};
      pin_m2_q <= pin_m1_q;
      enc_m1_q <= {i_sample_clock_pos, i_sample_clock_neg};
      enc_m2_q <= enc_m1_q;
    end
  end

  // --------------------------------------------------------------
  // effective configuration
  // --------------------------------------------------------------
  logic      par_mode;
  logic [1:0] ser_mode_code;
  out_mode_e ser_mode;
  cfg_s      ser_cfg;
  cfg_s      par_cfg;
  cfg_s      cfg;

  assign par_mode      = pin_m2_q[3];
  assign ser_mode_code = cfg_m2_q[4:3];
  assign ser_mode = (ser_mode_code == `ADC_MODE_CODE_DDR)  ? MODE_DDR_CMOS :
                    (ser_mode_code == `ADC_MODE_CODE_LVDS) ? MODE_DDR_LVDS :
                                                             MODE_FULL_CMOS;
  assign ser_cfg = '{mode: ser_mode, twos: cfg_m2_q[0],
                     dcs: cfg_m2_q[7], sleep: cfg_m2_q[8],
                     phase: cfg_m2_q[6:5],
                     drive_half: cfg_m2_q[2],
                     term: cfg_m2_q[1]};
  // parallel pins never reach DDR CMOS
  assign par_cfg = '{mode: pin_m2_q[1] ? MODE_DDR_LVDS
                                       : MODE_FULL_CMOS,
                     twos: 1'b0,
                     dcs: pin_m2_q[2],
                     sleep: pin_m2_q[0],
                     phase: 2'h0,
                     drive_half: 1'b0,
                     term: 1'b0};
  assign cfg = par_mode ? par_cfg : ser_cfg;

  // --------------------------------------------------------------
  // conversion start and sample period
  // --------------------------------------------------------------
  localparam logic [CW-1:0] STOP_CYC = CW'(`ADC_STOP_CYC);

  logic          enc_lvl_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] per_q;
  logic          enc_lvl;
  logic          start;
  logic          stopped;
  logic [CW-1:0] per_new;
  logic [CW-1:0] per_diff;
  logic          per_moved;

  // differential: pos high and neg low; single-ended: neg grounded
  assign enc_lvl   = enc_m2_q[1] & ~enc_m2_q[0];
  assign start     = enc_lvl & ~enc_lvl_q & ~cfg.sleep;
  assign stopped   = cnt_q >= STOP_CYC;
  assign per_new   = cnt_q + CW'(1);
  assign per_diff  = (per_new > per_q) ? per_new - per_q : per_q - per_new;
  assign per_moved = per_diff > CW'(`ADC_PERIOD_TOL);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enc_lvl_q <= 1'b0;
      cnt_q     <= STOP_CYC;
      per_q     <= '0;
    end else begin
      enc_lvl_q <= enc_lvl;
      if (start) begin
        cnt_q <= '0;
        per_q <= per_new;
      end else if (!stopped) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  // --------------------------------------------------------------
  // duty stabilizer lock tracking
  // --------------------------------------------------------------
  logic [6:0] lock_cnt_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_cnt_q <= 7'h00;
    end else if (!cfg.dcs || stopped || (start && per_moved)) begin
      lock_cnt_q <= 7'h00;
    end else if (start && lock_cnt_q != `ADC_LOCK_CYCLES) begin
      lock_cnt_q <= lock_cnt_q + 7'h01;
    end
  end

  // --------------------------------------------------------------
  // fixed-latency pipeline
  // --------------------------------------------------------------
  sample_s pipe_q [LATENCY];
  sample_s word_q;
  logic    fmt_ddr_q;
  logic    fmt_twos_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_q[i] <= '0;
      end
      word_q     <= '0;
      fmt_ddr_q  <= 1'b0;
      fmt_twos_q <= 1'b0;
    end else if (start) begin
      pipe_q[0] <= i_conv_sample;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
      word_q <= pipe_q[LATENCY-1];
      // format and mode switch only at a word boundary
      fmt_ddr_q  <= cfg.mode != MODE_FULL_CMOS;
      fmt_twos_q <= cfg.twos;
    end
  end

  // --------------------------------------------------------------
  // output formatting and forwarded clock
  // --------------------------------------------------------------
  logic [13:0]   code_fmt;
  logic [6:0]    even_bits;
  logic [6:0]    odd_bits;
  logic [CW-1:0] half;
  logic [CW-1:0] dly;
  logic [CW-1:0] pos;
  logic          first_half;
  logic          is_ddr;
  logic          live;
  logic [13:0]   word_d;
  logic [6:0]    pair_d;
  logic          fclk_d;

  assign code_fmt = fmt_twos_q ? {~word_q.code[13], word_q.code[12:0]}
                               : word_q.code;
  for (genvar g = 0; g < 7; g++) begin : g_pair
    assign even_bits[g] = code_fmt[2*g];
    assign odd_bits[g]  = code_fmt[2*g+1];
  end

  assign half       = per_q >> 1;
  assign dly        = CW'((per_q >> 2) * cfg.phase);
  assign pos        = (cnt_q >= dly) ? cnt_q - dly : CW'(cnt_q + per_q - dly);
  assign first_half = cnt_q < half;
  assign is_ddr     = fmt_ddr_q;
  assign live       = ~cfg.sleep & ~stopped;
  // clock low in the first half-period at phase 0, so data moves on its fall
  assign fclk_d     = live & (pos >= half);
  assign word_d     = (live & ~is_ddr) ? code_fmt : 14'h0000;
  assign pair_d     = ~(live & is_ddr) ? 7'h00 :
                      first_half ? even_bits : odd_bits;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample_word_lines   <= 14'h0000;
      o_ddr_bit_pair_line   <= 7'h00;
      o_forwarded_clock_pos <= 1'b0;
      o_forwarded_clock_neg <= 1'b1;
      o_range_exceeded_flag <= 1'b0;
    end else begin
      o_sample_word_lines   <= word_d;
      o_ddr_bit_pair_line   <= pair_d;
      o_forwarded_clock_pos <= fclk_d;
      o_forwarded_clock_neg <= ~fclk_d;
      o_range_exceeded_flag <= live & word_q.over;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lvds_enable     <= 1'b0;
      o_lvds_drive_half <= 1'b0;
      o_lvds_term_en    <= 1'b0;
      o_dcs_enable      <= 1'b0;
      o_dcs_locked      <= 1'b0;
      o_sleep           <= 1'b0;
    end else begin
      o_lvds_enable     <= cfg.mode == MODE_DDR_LVDS;
      o_lvds_drive_half <= cfg.drive_half;
      o_lvds_term_en    <= cfg.term;
      o_dcs_enable      <= cfg.dcs;
      o_dcs_locked      <= lock_cnt_q == `ADC_LOCK_CYCLES;
      o_sleep           <= cfg.sleep;
    end
  end

endmodule

// ===== tb/adc_output_and_config_port_bench.sv
// Purpose: self-checking bench of the converter output and config port
// Assumes: sample clock of 8 i_clk cycles, latency parameter 5
// Notes:   word model is a queue of samples taken at each start
`timescale 1ns/10ps
module adc_output_and_config_port_bench;
  import adc_port_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        i_clk, i_rst, strap, pos, neg, fc_prev, chk_on;
  logic        exp_ddr, exp_twos, sclk, cs_n, sdi, fc_p, fc_n, flag;
  logic        lvds, half, term, dcs, lock, slp, sdo_o, sdo_oe;
  logic [13:0] word;
  logic [6:0]  ddr;
  logic [7:0]  rd;
  sample_s     conv;
  sample_s     q[$];
  int          fails, total_checks, cyc, k, last_k, seed;

  adc_output_and_config_port #(.LATENCY(5), .CW(10)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_serial_clk(sclk),
    .i_program_path_strap(strap), .i_chip_select_n(cs_n),
    .i_serial_data_in(sdi), .i_sample_clock_pos(pos),
    .i_sample_clock_neg(neg), .i_conv_sample(conv),
    .o_sample_word_lines(word), .o_ddr_bit_pair_line(ddr),
    .o_forwarded_clock_pos(fc_p), .o_forwarded_clock_neg(fc_n),
    .o_range_exceeded_flag(flag), .o_lvds_enable(lvds),
    .o_lvds_drive_half(half), .o_lvds_term_en(term), .o_dcs_enable(dcs),
    .o_dcs_locked(lock), .o_sleep(slp), .o_serial_data_out(sdo_o),
    .o_serial_data_oe(sdo_oe));
  adc_port_host host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_oe(sdo_oe));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ---------------------------------------------------------------
  // sample clock and conversion results
  // ---------------------------------------------------------------
  initial begin
    pos  = 1'b0;
    neg  = 1'b1;
    conv = 15'h0000;
    forever begin
      repeat (4) @(posedge i_clk);
      #1 pos = 1'b1;
      neg = 1'b0;
      if (!i_rst) q.push_back(conv);
      repeat (4) @(posedge i_clk);
      #1 pos = 1'b0;
      neg = 1'b1;
      conv = 15'($urandom);
    end
  end

  function automatic logic [13:0] xcode(input int n);
    return q[n].code ^ (exp_twos ? 14'h2000 : 14'h0000);
  endfunction
  function automatic logic [6:0] pick(input logic [13:0] c, input int o);
    for (int g = 0; g < 7; g++) pick[g] = c[2*g+o];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // output model compared at each forwarded clock fall, and at each rise in DDR mode
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    #2;
    if (chk_on && fc_prev !== fc_p) begin
      k = q.size() - 6;
      if (!fc_p && k >= 0) begin
        last_k = k;
        if (exp_ddr) check({9'h0, ddr}, {9'h0, pick(xcode(k), 0)});
        else check({2'h0, word}, {2'h0, xcode(k)});
        check({15'h0, flag}, {15'h0, q[k].over});
      end else if (fc_p && exp_ddr && last_k >= 0)
        check({9'h0, ddr}, {9'h0, pick(xcode(last_k), 1)});
    end
    fc_prev = fc_p;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic samples(input int n);
    repeat (n) @(posedge pos);
  endtask
  task automatic rdreg(input logic [6:0] a);
    host_u.xfer({1'b1, a, 8'h00}, rd);
  endtask
  task automatic cfg(input logic [6:0] a, input logic [7:0] d);
    chk_on = 1'b0;
    last_k = -1;
    host_u.xfer({1'b0, a, d}, rd);
    samples(3);
    chk_on = 1'b1;
  endtask
  task automatic do_reset(input logic s);
    @(negedge pos);
    i_rst = 1'b1;
    strap = s;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    q.delete();
    last_k = -1;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    seed = $urandom(4);
    {chk_on, exp_ddr, exp_twos, strap, fc_prev} = 5'h00;
    last_k = -1;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    for (int a = 0; a < 5; a++) begin
      rdreg(a == 4 ? 7'h7F : 7'(a));
      check({8'h00, rd}, 16'h0000);
    end
    check({11'h0, lvds, half, term, dcs, slp}, 16'h0000);
    chk_on = 1'b1;
    samples(20);
    $display("test reset values and full-rate done");
    exp_twos = 1'b1;
    cfg(7'h03, 8'h01);
    rdreg(7'h03);
    check({8'h00, rd}, 16'h0001);
    samples(20);
    $display("test twos complement done");
    exp_ddr = 1'b1;
    cfg(7'h02, 8'h01);
    check({15'h0, lvds}, 16'h0000);
    samples(20);
    $display("test ddr cmos done");
    cfg(7'h02, 8'h0E);
    rdreg(7'h02);
    check({8'h00, rd}, 16'h000E);
    check({13'h0, lvds, half, term}, 16'h0007);
    samples(20);
    host_u.stray(16'h0200);
    rdreg(7'h02);
    check({8'h00, rd}, 16'h000E);
    $display("test lvds and chip select gating done");
    cfg(7'h01, 8'h01);
    check({15'h0, dcs}, 16'h0001);
    samples(50);
    check({15'h0, lock}, 16'h0000);
    samples(60);
    check({15'h0, lock}, 16'h0001);
    $display("test stabilizer lock done");
    chk_on = 1'b0;
    host_u.set_pins(1'b1, 1'b1, 1'b0);
    exp_twos = 1'b0;
    do_reset(1'b1);
    chk_on = 1'b1;
    samples(20);
    check({12'h0, lvds, half, term, dcs}, 16'h0009);
    chk_on = 1'b0;
    exp_ddr = 1'b0;
    host_u.set_pins(1'b1, 1'b0, 1'b0);
    samples(3);
    last_k = -1;
    chk_on = 1'b1;
    samples(10);
    check({15'h0, lvds}, 16'h0000);
    host_u.set_pins(1'b0, 1'b0, 1'b0);
    samples(2);
    check({15'h0, dcs}, 16'h0000);
    $display("test parallel pins done");
    chk_on = 1'b0;
    host_u.set_pins(1'b0, 1'b0, 1'b1);
    repeat (300) @(posedge i_clk);
    #1;
    check({15'h0, slp}, 16'h0001);
    check({2'h0, word}, 16'h0000);
    $display("test sleep done");
    end_of_test();
  end
endmodule

// ===== tb/adc_port_chk.sv
// Purpose: port checks of the converter output and configuration port
// Assumes: all checks sampled on i_clk
// Notes:   bind at the foot
`timescale 1ns/10ps
module adc_port_chk (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_program_path_strap,
  input wire logic        i_chip_select_n,
  input wire logic [13:0] o_sample_word_lines,
  input wire logic [6:0]  o_ddr_bit_pair_line,
  input wire logic        o_forwarded_clock_pos,
  input wire logic        o_forwarded_clock_neg,
  input wire logic        o_lvds_enable,
  input wire logic        o_dcs_enable,
  input wire logic        o_dcs_locked,
  input wire logic        o_sleep,
  input wire logic        o_serial_data_out,
  input wire logic        o_serial_data_oe
);
  // ---------------------------------------------------------------
  // cycles since stabilizer enable
  // ---------------------------------------------------------------
  logic [15:0] en_cnt_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) en_cnt_q <= 16'h0000;
    else if (!o_dcs_enable) en_cnt_q <= 16'h0000;
    else if (en_cnt_q != 16'hFFFF) en_cnt_q <= en_cnt_q + 16'h0001;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  clk_inverse_a: assert property (o_forwarded_clock_neg == !o_forwarded_clock_pos)
    else $error("forwarded clock pair not inverse");
  sdo_low_only_a: assert property (o_serial_data_out == 1'b0)
    else $error("serial output drives high");
  oe_cs_idle_a: assert property (i_chip_select_n [*2] |-> !o_serial_data_oe)
    else $error("serial output pulls with chip select high");
  par_no_sdo_a: assert property (i_program_path_strap |-> !o_serial_data_oe)
    else $error("serial output active in parallel mode");
  word_on_fall_a: assert property (($changed(o_sample_word_lines) &&
      o_sample_word_lines != 14'h0000) |-> $fell(o_forwarded_clock_pos))
    else $error("word changed off the clock fall");
  ddr_both_edges_a: assert property (($changed(o_ddr_bit_pair_line) &&
      o_ddr_bit_pair_line != 7'h00) |-> $changed(o_forwarded_clock_pos))
    else $error("pair lines changed off a clock edge");
  par_no_cmos_ddr_a: assert property ((i_program_path_strap &&
      !o_lvds_enable) |-> ##[0:32] o_ddr_bit_pair_line == 7'h00)
    else $error("cmos ddr output in parallel mode");
  lock_wait_a: assert property ($rose(o_dcs_locked) |-> en_cnt_q >= 16'h0190)
    else $error("stabilizer locked too early");
  sleep_quiet_a: assert property ($rose(o_sleep) |-> ##[0:250]
      (o_sample_word_lines == 14'h0000 && o_ddr_bit_pair_line == 7'h00))
    else $error("outputs still active in sleep");
endmodule

bind adc_output_and_config_port adc_port_chk chk_u (
  .i_clk, .i_rst, .i_program_path_strap, .i_chip_select_n,
  .o_sample_word_lines, .o_ddr_bit_pair_line, .o_forwarded_clock_pos,
  .o_forwarded_clock_neg, .o_lvds_enable, .o_dcs_enable, .o_dcs_locked,
  .o_sleep, .o_serial_data_out, .o_serial_data_oe
);

// ===== tb/adc_port_host.sv
// Purpose: serial host and pin driver facing the converter port
// Assumes: 160 ns serial clock, clock idles low between frames
// Notes:   sdo wire modelled with its pull-up
`timescale 1ns/10ps
module adc_port_host (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_oe
);
  // ---------------------------------------------------------------
  // open-drain wire with pull-up
  // ---------------------------------------------------------------
  wire sdo;
  assign sdo = i_oe ? 1'b0 : 1'b1;

  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame, msb first, cs low throughout
  // ---------------------------------------------------------------
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    r = 8'h00;
    #1.3;
    o_cs_n = 1'b0;
    #80;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = f[i];
      #80 o_sclk = 1'b1;
      #80;
      if (i <= 7) r[i] = sdo;
      o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #160;
  endtask

  // clock pulses with cs high; must shift nothing
  task automatic stray(input logic [15:0] f);
    for (int i = 15; i >= 0; i--) begin
      o_sdi = f[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    #160;
  endtask

  // parallel mode levels; sdo left alone
  task automatic set_pins(input logic cs, input logic sck, input logic d);
    o_cs_n = cs;
    o_sclk = sck;
    o_sdi  = d;
  endtask
endmodule
